//--- dv/dpll_trim_props.sv
`timescale 1ns/1ps
// ***
// port checker
// ***
module dpll_trim_props #(
   parameter int HOLD_CYCLES = 20
) (
   input wire logic aclk, // clock
   input wire logic aresetn, // reset, low
   input wire logic s_axi_wvalid, // data valid
   input wire logic s_axi_wready, // data ready
   input wire logic s_axi_arvalid, // read addr valid
   input wire logic s_axi_arready, // read addr ready
   input wire logic s_axi_rvalid, // read valid
   input wire logic ref_lost, // loss pulse
   input wire logic [15:0] trim_q, // applied trim
   input wire logic [4:0] bw_q, // bandwidth step
   input wire logic select_next_q, // next source
   input wire logic holdover_q, // hold
   input wire logic [15:0] pbo_offset_q // offset
);
   logic [15:0] cnt_q, cnt_d;
   logic [3:0] age_q, age_d;
   // hold length so far; age of last data beat saturates so it never wraps to look fresh
   always_comb begin
      cnt_d = holdover_q ? cnt_q + 16'h0001 : 16'h0000;
      age_d = (s_axi_wvalid && s_axi_wready) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
   end
   always_ff @(posedge aclk) begin
      cnt_q <= aresetn ? cnt_d : 16'h0000;
      age_q <= aresetn ? age_d : 4'hF;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_trim_rst; $rose(aresetn) |-> trim_q == 16'h9999 && bw_q == 5'h11; endproperty
   a_trim_rst: assert property (p_trim_rst) else $error("bad reset values");
   property p_bw_range; bw_q < 5'h12; endproperty
   a_bw_range: assert property (p_bw_range) else $error("bandwidth out of range");
   property p_sel; ref_lost |=> select_next_q; endproperty
   a_sel: assert property (p_sel) else $error("no switch after loss");
   property p_sel_one; !ref_lost |=> !select_next_q; endproperty
   a_sel_one: assert property (p_sel_one) else $error("stray switch");
   property p_hold_len; holdover_q |-> cnt_q < HOLD_CYCLES; endproperty
   a_hold_len: assert property (p_hold_len) else $error("hold too long");
   property p_hold_end; $fell(holdover_q) |-> cnt_q == HOLD_CYCLES; endproperty
   a_hold_end: assert property (p_hold_end) else $error("hold too short");
   property p_off_hold; holdover_q && $past(holdover_q) |-> $stable(pbo_offset_q); endproperty
   a_off_hold: assert property (p_off_hold) else $error("offset moved in hold");
   property p_trim_pair; $changed(trim_q) |-> age_q < 4'h5; endproperty
   a_trim_pair: assert property (p_trim_pair) else $error("trim moved unasked");
   property p_rv; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
   a_rv: assert property (p_rv) else $error("no read answer");
endmodule
bind dpll_freq_trim_phase_buildout dpll_trim_props #(.HOLD_CYCLES(HOLD_CYCLES)) props_u (.*);

//--- dv/ref_source_model.sv
`timescale 1ns/1ps
// ***
// reference source and loop status
// ***
module ref_source_model (
   input wire logic aclk, // clock
   input wire logic lose_req, // ask for a loss
   input wire logic lock_req, // ask for lock
   input wire logic [15:0] err_req, // error to show
   output logic locked = 1'b0, // loop locked
   output logic ref_lost = 1'b0, // loss pulse
   output logic [15:0] phase_err = 16'h0000 // phase error
);
   // outputs move just after the edge, as a real source would
   always @(posedge aclk) begin
      ref_lost <= lose_req & ~ref_lost; // one pulse per loss
      locked <= lock_req;
      phase_err <= err_req;
   end
endmodule

//--- dv/test_dpll_freq_trim_phase_buildout.sv
`timescale 1ns/1ps
// ***
// bench
// ***
module test_dpll_freq_trim_phase_buildout;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, lose_req = 1'b0, lock_req = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic locked, ref_lost, select_next_q, holdover_q, irq_q, i0;
   logic [15:0] phase_err, trim_q, pbo_offset_q, err_req = 16'h0;
   logic [4:0] bw_q;
   int n_mismatch = 0, n_tests = 0, cyc = 0, m_trim, m_off = 0;
   int tv[$];
   dpll_freq_trim_phase_buildout #(.HOLD_CYCLES(8)) dut_u (.*);
   ref_source_model src_u (.aclk(aclk), .lose_req(lose_req), .lock_req(lock_req), .err_req(err_req),
      .locked(locked), .ref_lost(ref_lost), .phase_err(phase_err));
   initial begin
      forever #2.5 aclk = ~aclk;
   end
   task automatic report_and_stop();
      if (n_mismatch == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // a hang ends here, far past the expected few hundred cycles
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // each channel is released on its own handshake edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic lose();
      @(posedge aclk);
      lose_req <= 1'b1;
      @(posedge aclk);
      lose_req <= 1'b0;
   endtask
   // wait out one hold and fold the measured error into the model offset
   task automatic hold();
      do @(posedge aclk); while (!holdover_q);
      do @(posedge aclk); while (holdover_q);
      @(posedge aclk);
      m_off = (m_off + phase_err) & 16'hFFFF;
      chk(pbo_offset_q, m_off);
   endtask
   // ***
   // main sequence
   // ***
   initial begin
      void'($urandom(32'hB87D));
      tv = '{0, 16'hFFFF, $urandom & 16'hFFFF, 16'h9999};
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(8'h0C);
      chk(d, 32'h5);
      m_trim = 16'h9999;
      // halves in both orders; applied value holds until the pair is complete
      foreach (tv[i]) begin
         wr(i[0] ? 8'h04 : 8'h00, (i[0] ? tv[i] >> 8 : tv[i]) & 8'hFF);
         chk(trim_q, m_trim);
         wr(i[0] ? 8'h00 : 8'h04, (i[0] ? tv[i] : tv[i] >> 8) & 8'hFF);
         @(posedge aclk);
         m_trim = tv[i];
         chk(trim_q, m_trim);
         rd(8'h18);
         chk(d, m_trim);
      end
      wr(8'h40, 32'h1);
      chk(resp, 2'b10);
      rd(8'h40);
      chk(d, 32'h0);
      chk(resp, 2'b10);
      for (int i = 0; i < 18; i++) begin
         wr(8'h08, (i << 8) | (17 - i));
         lock_req <= 1'b0;
         repeat (4) @(posedge aclk);
         chk(bw_q, 17 - i);
         lock_req <= 1'b1;
         repeat (4) @(posedge aclk);
         chk(bw_q, i);
      end
      err_req <= 16'h5;
      lose();
      hold();
      rd(8'h10);
      chk(d[2], 1'b1);
      // mask polarity found by comparison; only one setting may pass the event
      wr(8'h14, 32'h0);
      @(posedge aclk);
      i0 = irq_q;
      wr(8'h14, 32'h7);
      @(posedge aclk);
      chk(i0 ^ irq_q, 1'b1);
      wr(8'h10, 32'h7);
      @(posedge aclk);
      chk(irq_q, 1'b0);
      wr(8'h14, i0 ? 32'h0 : 32'h7);
      wr(8'h0C, 32'h1);
      wr(8'h08, (5 << 13) | (17 << 8));
      rd(8'h08);
      chk(d, (5 << 13) | (17 << 8));
      err_req <= 16'd30;
      repeat (4) @(posedge aclk);
      rd(8'h10);
      chk(d[0], 1'b0);
      err_req <= 16'd40;
      repeat (4) @(posedge aclk);
      chk({irq_q, holdover_q}, 2'b10);
      wr(8'h20, 32'h1);
      hold();
      err_req <= 16'h3;
      wr(8'h0C, 32'h7);
      lose();
      repeat (4) @(posedge aclk);
      chk({holdover_q, pbo_offset_q}, m_off);
      wr(8'h0C, 32'h4);
      @(posedge aclk);
      m_off = 0;
      chk(pbo_offset_q, m_off);
      wr(8'h0C, 32'h5);
      hold();
      report_and_stop();
   end
endmodule

//--- hdl/bw_select.sv
`timescale 1ns/1ps
`include "dpll_ctrl_consts.svh"
module bw_select (
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, low
   input wire logic locked, // loop phase locked
   input wire logic holdover, // loop in holdover
   input wire logic [4:0] bw_acq, // acquisition setting
   input wire logic [4:0] bw_lock, // locked setting
   output logic [4:0] bw_q // active setting
);
   logic [4:0] bw_d;
   logic [4:0] pick;
   // out-of-range codes clamp to the widest step so the filter stays defined
   always_comb begin
      pick = locked ? bw_lock : bw_acq;
      bw_d = holdover ? bw_q : pick;
      if (bw_d >= `BW_STEPS) begin
         bw_d = `BW_STEPS - 5'h01;
      end
   end
   // register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bw_q <= `BW_ACQ_RESET;
      end else begin
         bw_q <= bw_d;
      end
   end
endmodule

//--- hdl/dpll_freq_trim_phase_buildout.sv
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dpll_ctrl_consts.svh"
module dpll_freq_trim_phase_buildout #(
   parameter int HOLD_CYCLES = `HOLD_CYCLES
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // response valid
   input wire logic s_axi_bready, // response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic locked, // loop phase locked
   input wire logic ref_lost, // selected reference lost, pulse
   input wire logic [15:0] phase_err, // input minus output phase, 100 ns units
   output logic [15:0] trim_q, // applied frequency trim
   output logic [4:0] bw_q, // active bandwidth step
   output logic select_next_q, // pick next priority source, pulse
   output logic holdover_q, // temporary holdover
   output logic [15:0] pbo_offset_q, // compensating phase offset
   output logic irq_q // interrupt, high
);
   // ****************************************
   // bus slave
   // ****************************************
   logic aw_q, aw_d, w_q, w_d, bv_d, rv_d;
   logic [7:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_d;
   logic [3:0] ws_q, ws_d;
   logic [1:0] br_d, rr_d;
   logic wr_go;
   logic [4:0] bw_acq_q, bw_acq_d, bw_lock_q, bw_lock_d;
   logic [3:0] thr_q, thr_d;
   logic [2:0] ctrl_q, ctrl_d, st_q, st_d, mask_q, mask_d;
   logic [7:0] lo_v, hi_v;
   logic cmd_pbo;
   logic [2:0] ev;
   logic pbo_en_rise;
   logic en_q;
   logic ev_done_q;
   dpll_ctrl_pkg::pbo_state_e ps_q, ps_d;
   logic [15:0] hcnt_q, hcnt_d, off_d;
   logic hold_d, sel_d, irq_d;
   logic [15:0] mag;
   logic jump;
   logic trig;

   wire mapped_w = awa_q <= `REG_PBO_CMD && awa_q[1:0] == 2'b00;
   assign wr_go = aw_q && w_q && !s_axi_bvalid;
   wire wr_lo = wr_go && awa_q == `REG_TRIM_LO && ws_q[0];
   wire wr_hi = wr_go && awa_q == `REG_TRIM_HI && ws_q[0];

   // capture address and data in either order, answer once both held
   always_comb begin
      aw_d = aw_q;
      w_d = w_q;
      awa_d = awa_q;
      wd_d = wd_q;
      ws_d = ws_q;
      bv_d = s_axi_bvalid;
      br_d = s_axi_bresp;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_d = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb;
      end
      if (wr_go) begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         br_d = mapped_w ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
         bv_d = 1'b0;
      end
   end

   // read decode; unmapped addresses answer slverr
   always_comb begin
      rv_d = s_axi_rvalid;
      rd_d = s_axi_rdata;
      rr_d = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready) begin
         rv_d = 1'b1;
         rr_d = 2'b00;
         case (s_axi_araddr)
            `REG_TRIM_LO: rd_d = {24'h000000, lo_v};
            `REG_TRIM_HI: rd_d = {24'h000000, hi_v};
            `REG_BW: rd_d = {15'h0000, thr_q, bw_lock_q, 3'h0, bw_acq_q};
            `REG_PBO_CTRL: rd_d = {29'h00000000, ctrl_q};
            `REG_STATUS: rd_d = {28'h0000000, holdover_q, st_q};
            `REG_IRQ_MASK: rd_d = {29'h00000000, mask_q};
            `REG_TRIM_ACT: rd_d = {16'h0000, trim_q};
            `REG_PBO_OFFSET: rd_d = {16'h0000, pbo_offset_q};
            `REG_PBO_CMD: rd_d = 32'h00000000;
            default: begin
               rd_d = 32'h00000000;
               rr_d = 2'b10;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         rv_d = 1'b0;
      end
   end

   // bus registers; readies drop while a channel holds an untaken item
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awa_q <= 8'h00;
         wd_q <= 32'h00000000;
         ws_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else begin
         aw_q <= aw_d;
         w_q <= w_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         ws_q <= ws_d;
         s_axi_awready <= !aw_d && !bv_d;
         s_axi_wready <= !w_d && !bv_d;
         s_axi_bvalid <= bv_d;
         s_axi_bresp <= br_d;
         s_axi_arready <= !rv_d && !(s_axi_arvalid && s_axi_arready);
         s_axi_rvalid <= rv_d;
         s_axi_rdata <= rd_d;
         s_axi_rresp <= rr_d;
      end
   end

   // ****************************************
   // control registers and sticky status
   // ****************************************
   assign cmd_pbo = wr_go && awa_q == `REG_PBO_CMD && ws_q[0] && wd_q[0];
   // a set in the same cycle as a write-one clear wins
   always_comb begin
      bw_acq_d = bw_acq_q;
      bw_lock_d = bw_lock_q;
      thr_d = thr_q;
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      st_d = st_q;
      if (wr_go && awa_q == `REG_BW) begin
         if (ws_q[0]) bw_acq_d = wd_q[4:0];
         if (ws_q[1]) bw_lock_d = wd_q[12:8];
         if (ws_q[1] && wd_q[12:8] >= `BW_STEPS) bw_lock_d = `BW_STEPS - 5'h01;
         if (ws_q[1]) thr_d = (wd_q[16:13] > `THRESH_MAX) ? `THRESH_MAX : wd_q[16:13];
      end
      if (wr_go && awa_q == `REG_PBO_CTRL && ws_q[0]) ctrl_d = wd_q[2:0];
      if (wr_go && awa_q == `REG_IRQ_MASK && ws_q[0]) mask_d = wd_q[2:0];
      if (wr_go && awa_q == `REG_STATUS && ws_q[0]) st_d = st_q & ~wd_q[2:0];
      st_d = st_d | ev;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bw_acq_q <= `BW_ACQ_RESET;
         bw_lock_q <= `BW_LOCK_RESET;
         thr_q <= `THRESH_RESET;
         ctrl_q <= 3'b101; // enabled, not frozen, automatic
         mask_q <= 3'b000;
         st_q <= 3'b000;
         en_q <= 1'b1;
      end else begin
         bw_acq_q <= bw_acq_d;
         bw_lock_q <= bw_lock_d;
         thr_q <= thr_d;
         ctrl_q <= ctrl_d;
         mask_q <= mask_d;
         st_q <= st_d;
         en_q <= ctrl_q[`PBO_EN_BIT];
      end
   end

   // ****************************************
   // phase build-out sequencer
   // ****************************************
   // threshold steps are 0.5 us from 1 us; phase_err counts 100 ns units
   always_comb begin
      mag = phase_err[15] ? (~phase_err + 16'h0001) : phase_err;
      jump = locked && (mag > (16'd10 + {12'h000, thr_q} * 16'd5));
      pbo_en_rise = ctrl_q[`PBO_EN_BIT] && !en_q && locked;
      ev = {ref_lost, ev_done_q, jump};
      // frozen or disabled build-out ignores every trigger
      trig = ctrl_q[`PBO_EN_BIT] && !ctrl_q[`PBO_FREEZE_BIT] && ps_q == dpll_ctrl_pkg::PBO_IDLE &&
             (ref_lost || pbo_en_rise || cmd_pbo || (jump && ctrl_q[`PBO_AUTO_BIT]));
      ps_d = ps_q;
      hcnt_d = hcnt_q;
      off_d = pbo_offset_q;
      hold_d = 1'b0;
      sel_d = ref_lost;
      case (ps_q)
         dpll_ctrl_pkg::PBO_IDLE: begin
            hcnt_d = 16'h0000;
            if (trig) ps_d = dpll_ctrl_pkg::PBO_HOLD;
         end
         dpll_ctrl_pkg::PBO_HOLD: begin
            hold_d = 1'b1;
            hcnt_d = hcnt_q + 16'h0001;
            if (hcnt_q >= 16'(HOLD_CYCLES - 1)) ps_d = dpll_ctrl_pkg::PBO_APPLY;
         end
         dpll_ctrl_pkg::PBO_APPLY: begin
            off_d = pbo_offset_q + phase_err;
            ps_d = dpll_ctrl_pkg::PBO_IDLE;
         end
         default: ps_d = dpll_ctrl_pkg::PBO_IDLE;
      endcase
      if (!ctrl_q[`PBO_EN_BIT]) off_d = 16'h0000;
      irq_d = |(st_d & mask_q);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ps_q <= dpll_ctrl_pkg::PBO_IDLE;
         hcnt_q <= 16'h0000;
         pbo_offset_q <= 16'h0000;
         holdover_q <= 1'b0;
         select_next_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         ps_q <= ps_d;
         hcnt_q <= hcnt_d;
         pbo_offset_q <= off_d;
         holdover_q <= hold_d;
         select_next_q <= sel_d;
         irq_q <= irq_d;
      end
   end

   // the event bit marks each build-out that actually ran
   always_ff @(posedge aclk) begin
      if (!aresetn) ev_done_q <= 1'b0;
      else ev_done_q <= trig;
   end

   // ****************************************
   // trim pair and bandwidth selection
   // ****************************************
   // trim_q feeds the synthesis: each lsb is 0.0196229 ppm, 0..65535 = -771..+514 ppm
   trim_pair u_trim (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_lo(wr_lo),
      .wr_hi(wr_hi),
      .wdata(wd_q[7:0]),
      .lo_q(lo_v),
      .hi_q(hi_v),
      .trim_q(trim_q)
   );

   bw_select u_bw (
      .aclk(aclk),
      .aresetn(aresetn),
      .locked(locked),
      .holdover(holdover_q),
      .bw_acq(bw_acq_q),
      .bw_lock(bw_lock_q),
      .bw_q(bw_q)
   );
endmodule

//--- hdl/trim_pair.sv
`timescale 1ns/1ps
`include "dpll_ctrl_consts.svh"
module trim_pair (
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, low
   input wire logic wr_lo, // low half write strobe
   input wire logic wr_hi, // high half write strobe
   input wire logic [7:0] wdata, // byte written
   output logic [7:0] lo_q, // staged low half
   output logic [7:0] hi_q, // staged high half
   output logic [15:0] trim_q // applied trim
);
   logic lo_seen_q, lo_seen_d, hi_seen_q, hi_seen_d;
   logic [7:0] lo_d, hi_d;
   logic [15:0] trim_d;
   // both halves must be seen before the pair is applied, in either order
   always_comb begin
      lo_d = wr_lo ? wdata : lo_q;
      hi_d = wr_hi ? wdata : hi_q;
      lo_seen_d = lo_seen_q | wr_lo;
      hi_seen_d = hi_seen_q | wr_hi;
      trim_d = trim_q;
      if (lo_seen_d && hi_seen_d) begin
         trim_d = {hi_d, lo_d};
         lo_seen_d = 1'b0;
         hi_seen_d = 1'b0;
      end
   end
   // registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lo_q <= 8'(`TRIM_RESET);
         hi_q <= 8'(`TRIM_RESET >> 8);
         trim_q <= `TRIM_RESET;
         lo_seen_q <= 1'b0;
         hi_seen_q <= 1'b0;
      end else begin
         lo_q <= lo_d;
         hi_q <= hi_d;
         trim_q <= trim_d;
         lo_seen_q <= lo_seen_d;
         hi_seen_q <= hi_seen_d;
      end
   end
endmodule

//--- inc/dpll_ctrl_consts.svh
// Summary of operation
// - one trim step moves outputs 0.0196229 ppm
// - trim resets to 9999 hex, zero offset
// - trim spans 0..65535, -771 to +514 ppm
// - trim held in two byte-wide locations
// - bandwidth switches acquisition to locked automatically
// - eighteen bandwidth settings, 0.5 mHz to 70 Hz
// - reference loss selects next source, triggers build-out
// - phase transient above programmable threshold triggers build-out
// - build-out automatic or externally controlled
// - external mode flags, interrupts; host commands event
// - event enters holdover, measures, adds compensating offset
// - build-out enabled at reset; disable or freeze
`ifndef DPLL_CTRL_CONSTS_SVH
`define DPLL_CTRL_CONSTS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define REG_TRIM_LO 8'h00
`define REG_TRIM_HI 8'h04
`define REG_BW 8'h08
`define REG_PBO_CTRL 8'h0C
`define REG_STATUS 8'h10
`define REG_IRQ_MASK 8'h14
`define REG_TRIM_ACT 8'h18
`define REG_PBO_OFFSET 8'h1C
`define REG_PBO_CMD 8'h20
// ****************************************
// fields and reset values
// ****************************************
`define TRIM_RESET 16'h9999
`define BW_ACQ_RESET 5'h11
`define BW_LOCK_RESET 5'h08
`define BW_STEPS 5'h12
`define THRESH_RESET 4'h0
`define THRESH_MAX 4'h5
`define PBO_EN_BIT 0
`define PBO_FREEZE_BIT 1
`define PBO_AUTO_BIT 2
`define ST_JUMP_BIT 0
`define ST_EVENT_BIT 1
`define ST_SWITCH_BIT 2
`define HOLD_TIME_NS 100
`define HOLD_CYCLES ((`HOLD_TIME_NS + 4) / 5)
`endif

//--- inc/dpll_ctrl_pkg.sv
package dpll_ctrl_pkg;
   typedef enum logic [1:0] {
      PBO_IDLE = 2'b00,
      PBO_HOLD = 2'b01,
      PBO_APPLY = 2'b10
   } pbo_state_e;
endpackage
